// file: hdl/asp_dev.sv
// Contract
// - works in mode 0 and 3 automatically
// - master clock at most 25MHz, no minimum
// - every command frame is 16 bits
// - sample rising, change falling, msb first
// - buffer reloads angle every microsecond when idle
// - chip select low freezes buffer until high
// - angle read: mosi zero, 16 bits out
// - unused low angle bits sent as zero
// - angle read may stop after fewer clocks
// - fast reads repeat the same angle value
// - read request is 010, address, eight zeros
// - read reply frame: value in upper byte
// - register 27 carries field high/low flags
// - write request is 100, address, data
// - write reply returns stored register value
// - master waits 20ms before write reply
// - early write reply returns previous value
// - reads need no nonvolatile write wait
// - written registers persist and reload at power-up; reset here loads zeros (0x1c in register 6) instead
// - chip select high 150ns between angle reads
// - chip select high 750ns around register frames; host waits it after them only, so one after an angle read gets 150ns
// - register 9 bit 7 sets counterclockwise
// - miso released when not selected
`timescale 1ns/1ps
`include "asp_map.svh"

module asp_dev
#(
    parameter int ANGLE_BITS    = 16,
    parameter int NVM_WAIT_CYC  = `ASP_NVM_WAIT_CYC
)
(
    input  wire logic        CORE_CLK_IN,
    input  wire logic        RST_N_IN,
    input  wire logic [15:0] ANGLE_IN,
    input  wire logic        FIELD_HIGH_FLAG_IN,
    input  wire logic        FIELD_LOW_FLAG_IN,
    output logic             ROT_CCW_OUT,
    asp_if.dev               LINK
);
    import asp_pkg::*;

    localparam logic [15:0] ANGLE_MASK =
        16'(17'h0ffff << (16 - ANGLE_BITS));
    localparam logic [7:0]  REFRESH_LAST = 8'(`ASP_REFRESH_CYC - 1);
    localparam logic [31:0] NVM_LAST     = 32'(NVM_WAIT_CYC - 1);

    asp_core_type q_reg;
    asp_core_type q_next;
    asp_link_type l_reg;
    asp_link_type l_next;
    logic         fe_fell_reg;
    logic         fe_bit_reg;
    logic         fe_fell_next;
    logic         fe_bit_next;
    logic         link_rst_n;
    logic [7:0]   rd_byte;
    logic         cs_fall;
    logic         cs_rise;
    logic         cmd_arrived;
    logic [2:0]   cmd_op;
    logic [15:0]  cmd_reg;
    logic         tg_reg;

    // the frame's own chip select ends the link-side state; no sclk
    // edge can be relied on once the master stops clocking
    assign link_rst_n = RST_N_IN & ~LINK.cs_n;

    function automatic logic writable(input logic [4:0] a);
        writable = (a == `ASP_REG_ZERO_LO) || (a == `ASP_REG_ZERO_HI) ||
                   (a == `ASP_REG_BIAS) || (a == `ASP_REG_TRIM_EN) ||
                   (a == `ASP_REG_FIELD_THR) || (a == `ASP_REG_POLES) ||
                   (a == `ASP_REG_DIR);
    endfunction

    // link side: sampling on rising edges only, so the idle level of
    // sclk never matters and both modes run untouched
    always_comb
    begin
        l_next     = l_reg;
        l_next.cmd = cmd_reg;
        l_next.tg  = tg_reg;
        if (l_reg.cnt != 5'(`ASP_FRAME_BITS))
        begin
            l_next.shift = {l_reg.shift[13:0], LINK.mosi};
            l_next.cnt   = l_reg.cnt + 5'h01;
        end
        if (l_reg.cnt == 5'(`ASP_FRAME_BITS - 1))
        begin
            l_next.cmd = {l_reg.shift, LINK.mosi};
            l_next.tg  = ~tg_reg;
        end
    end

    always_ff @(posedge LINK.sclk or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            l_reg <= '0;
        end
        else
        begin
            l_reg <= l_next;
        end
    end

    // command word and toggle survive chip select rising
    always_ff @(posedge LINK.sclk or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            cmd_reg <= 16'h0000;
            tg_reg  <= 1'b0;
        end
        else
        begin
            cmd_reg <= l_next.cmd;
            tg_reg  <= l_next.tg;
        end
    end

    // out_word is frozen while selected, so reading it here is safe
    always_comb
    begin
        fe_fell_next = 1'b1;
        fe_bit_next  = 1'b0;
        if (l_reg.cnt < 5'(`ASP_FRAME_BITS))
        begin
            fe_bit_next = q_reg.out_word[4'(5'd15 - l_reg.cnt)];
        end
    end

    always_ff @(negedge LINK.sclk or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            fe_fell_reg <= 1'b0;
            fe_bit_reg  <= 1'b0;
        end
        else
        begin
            fe_fell_reg <= fe_fell_next;
            fe_bit_reg  <= fe_bit_next;
        end
    end

    // mode 0 needs the msb before any falling edge; mode 3 gets it
    // from the first falling edge
    assign LINK.miso_o  = fe_fell_reg ? fe_bit_reg : q_reg.out_word[15];
    assign LINK.miso_oe = ~LINK.cs_n;

    // core side
    assign cs_fall     = q_reg.cs_d & ~q_reg.cs_s2;
    assign cs_rise     = ~q_reg.cs_d & q_reg.cs_s2;
    assign cmd_arrived = q_reg.tg_s2 ^ q_reg.tg_d;
    assign cmd_op      = cmd_reg[`ASP_CMD_MSB:`ASP_CMD_LSB];

    always_comb
    begin
        if (q_reg.addr == `ASP_REG_FLAGS)
        begin
            rd_byte = 8'h00;
            rd_byte[`ASP_FIELD_HIGH_BIT] = q_reg.fh_s2;
            rd_byte[`ASP_FIELD_LOW_BIT]  = q_reg.fl_s2;
        end
        else if (writable(q_reg.addr))
        begin
            rd_byte = q_reg.regs[q_reg.addr];
        end
        else
        begin
            rd_byte = 8'h00;
        end
    end

    always_comb
    begin
        q_next       = q_reg;
        q_next.cs_s1 = LINK.cs_n;
        q_next.cs_s2 = q_reg.cs_s1;
        q_next.cs_d  = q_reg.cs_s2;
        q_next.tg_s1 = tg_reg;
        q_next.tg_s2 = q_reg.tg_s1;
        q_next.tg_d  = q_reg.tg_s2;
        q_next.fh_s1 = FIELD_HIGH_FLAG_IN;
        q_next.fh_s2 = q_reg.fh_s1;
        q_next.fl_s1 = FIELD_LOW_FLAG_IN;
        q_next.fl_s2 = q_reg.fl_s1;

        if (q_reg.us_cnt == REFRESH_LAST)
        begin
            q_next.us_cnt = 8'h00;
        end
        else
        begin
            q_next.us_cnt = q_reg.us_cnt + 8'h01;
        end

        // buffer moves only while deselected
        if (q_reg.cs_s2 && !cs_rise)
        begin
            if (q_reg.st == DEV_ARMED)
            begin
                q_next.out_word = {rd_byte, 8'h00};
            end
            else if (q_reg.us_cnt == REFRESH_LAST)
            begin
                q_next.out_word = ANGLE_IN & ANGLE_MASK;
            end
        end
        // otherwise frozen

        case (q_reg.st)
            DEV_ARMED:
            begin
                if (cs_fall)
                begin
                    q_next.st = DEV_REPLY;
                end
            end
            DEV_REPLY:
            begin
                if (cs_rise)
                begin
                    q_next.st = DEV_ANGLE;
                end
            end
            default:
            begin
                q_next.st = DEV_ANGLE;
            end
        endcase

        // all-zero frames (angle reads, reply frames) leave state alone
        if (cmd_arrived)
        begin
            if (cmd_op == `ASP_CMD_READ)
            begin
                q_next.addr = cmd_reg[`ASP_ADDR_MSB:`ASP_ADDR_LSB];
                q_next.st   = DEV_ARMED;
            end
            else if (cmd_op == `ASP_CMD_WRITE)
            begin
                q_next.addr     = cmd_reg[`ASP_ADDR_MSB:`ASP_ADDR_LSB];
                q_next.wdata    = cmd_reg[`ASP_DATA_MSB:`ASP_DATA_LSB];
                q_next.nvm_busy = 1'b1;
                q_next.nvm_cnt  = 32'h0000_0000;
                q_next.st       = DEV_ARMED;
            end
        end

        // old value stays visible until the slow store completes
        if (q_reg.nvm_busy && !cmd_arrived)
        begin
            q_next.nvm_cnt = q_reg.nvm_cnt + 32'h0000_0001;
            if (q_reg.nvm_cnt == NVM_LAST)
            begin
                q_next.nvm_busy = 1'b0;
                if (writable(q_reg.addr))
                begin
                    q_next.regs[q_reg.addr] = q_reg.wdata;
                end
            end
        end
    end

    // reset loads the power-up defaults, not the values written before it
    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            q_reg       <= '0;
            q_reg.cs_s1 <= 1'b1;
            q_reg.cs_s2 <= 1'b1;
            q_reg.cs_d  <= 1'b1;
            q_reg.st    <= DEV_ANGLE;
            q_reg.regs[`ASP_REG_FIELD_THR] <= `ASP_FIELD_THR_RST;
        end
        else
        begin
            q_reg <= q_next;
        end
    end

    assign ROT_CCW_OUT = q_reg.regs[`ASP_REG_DIR][`ASP_DIR_BIT];

endmodule // asp_dev

// file: hdl/asp_host.sv
`timescale 1ns/1ps
`include "asp_map.svh"

module asp_host
#(
    parameter logic MODE3        = 1'b0,
    parameter int   NVM_WAIT_CYC = `ASP_NVM_WAIT_CYC
)
(
    input  wire logic               CORE_CLK_IN,
    input  wire logic               RST_N_IN,
    input  wire logic               REQ_IN,
    input  asp_pkg::asp_op_type     OP_IN,
    input  wire logic [4:0]         ADDR_IN,
    input  wire logic [7:0]         WDATA_IN,
    output logic                    BUSY_OUT,
    output logic                    DONE_OUT,
    output logic [15:0]             RDATA_OUT,
    asp_if.host                     LINK
);
    import asp_pkg::*;

    localparam logic [31:0] LEAD_LAST = 32'(`ASP_CS_LEAD_CYC - 1);
    localparam logic [31:0] HALF_LAST = 32'(`ASP_SCLK_HALF_CYC - 1);
    localparam logic [31:0] TAIL_LAST = 32'(`ASP_CS_TAIL_CYC - 1);

    asp_host_type h_reg;
    asp_host_type h_next;
    logic [31:0]  gap_last;

    // nvm wait after a write request, longer idle after register frames
    always_comb
    begin
        if (h_reg.op == OP_WRITE && !h_reg.second)
        begin
            gap_last = 32'(NVM_WAIT_CYC - 1);
        end
        else if (h_reg.op == OP_ANGLE)
        begin
            gap_last = 32'(`ASP_ANGLE_GAP_CYC - 1);
        end
        else
        begin
            gap_last = 32'(`ASP_REG_GAP_CYC - 1);
        end
    end

    always_comb
    begin
        h_next         = h_reg;
        h_next.miso_s1 = LINK.miso;
        h_next.miso_s2 = h_reg.miso_s1;
        h_next.done    = 1'b0;
        h_next.tmr     = h_reg.tmr + 32'h0000_0001;
        case (h_reg.st)
            HST_IDLE:
            begin
                h_next.tmr = 32'h0000_0000;
                if (REQ_IN)
                begin
                    h_next.op     = OP_IN;
                    h_next.second = 1'b0;
                    h_next.busy   = 1'b1;
                    if (OP_IN == OP_READ)
                    begin
                        h_next.tx = {`ASP_CMD_READ, ADDR_IN, 8'h00};
                    end
                    else if (OP_IN == OP_WRITE)
                    begin
                        h_next.tx = {`ASP_CMD_WRITE, ADDR_IN, WDATA_IN};
                    end
                    else
                    begin
                        h_next.tx = 16'h0000;
                    end
                    h_next.mosi = h_next.tx[15];
                    h_next.tx   = {h_next.tx[14:0], 1'b0};
                    h_next.cs_n = 1'b0;
                    h_next.bitn = 5'h00;
                    h_next.st   = HST_LEAD;
                end
            end
            HST_LEAD:
            begin
                if (h_reg.tmr == LEAD_LAST)
                begin
                    h_next.tmr  = 32'h0000_0000;
                    h_next.sclk = 1'b0;
                    h_next.st   = HST_LOW;
                end
            end
            HST_LOW:
            begin
                if (h_reg.tmr == HALF_LAST)
                begin
                    h_next.tmr  = 32'h0000_0000;
                    h_next.sclk = 1'b1;
                    h_next.st   = HST_HIGH;
                end
            end
            HST_HIGH:
            begin
                if (h_reg.tmr == HALF_LAST)
                begin
                    // synchronised sample is two cycles old, still
                    // inside the bit since it changed a full period ago
                    h_next.rx   = {h_reg.rx[14:0], h_reg.miso_s2};
                    h_next.bitn = h_reg.bitn + 5'h01;
                    h_next.tmr  = 32'h0000_0000;
                    if (h_reg.bitn == 5'(`ASP_FRAME_BITS - 1))
                    begin
                        h_next.sclk = MODE3;
                        h_next.st   = HST_TAIL;
                    end
                    else
                    begin
                        h_next.sclk = 1'b0;
                        h_next.mosi = h_reg.tx[15];
                        h_next.tx   = {h_reg.tx[14:0], 1'b0};
                        h_next.st   = HST_LOW;
                    end
                end
            end
            HST_TAIL:
            begin
                if (h_reg.tmr == TAIL_LAST)
                begin
                    h_next.cs_n = 1'b1;
                    h_next.mosi = 1'b0;
                    h_next.tmr  = 32'h0000_0000;
                    h_next.st   = HST_GAP;
                end
            end
            HST_GAP:
            begin
                if (h_reg.tmr == gap_last)
                begin
                    h_next.tmr = 32'h0000_0000;
                    if (h_reg.op != OP_ANGLE && !h_reg.second)
                    begin
                        h_next.second = 1'b1;
                        h_next.tx     = 16'h0000;
                        h_next.mosi   = 1'b0;
                        h_next.cs_n   = 1'b0;
                        h_next.bitn   = 5'h00;
                        h_next.st     = HST_LEAD;
                    end
                    else
                    begin
                        h_next.busy = 1'b0;
                        h_next.done = 1'b1;
                        if (h_reg.op == OP_ANGLE)
                        begin
                            h_next.rdata = h_reg.rx;
                        end
                        else
                        begin
                            h_next.rdata = {8'h00, h_reg.rx[15:8]};
                        end
                        h_next.st = HST_IDLE;
                    end
                end
            end
            default:
            begin
                h_next.st = HST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            h_reg      <= '0;
            h_reg.st   <= HST_IDLE;
            h_reg.op   <= OP_ANGLE;
            h_reg.cs_n <= 1'b1;
            h_reg.sclk <= MODE3;
        end
        else
        begin
            h_reg <= h_next;
        end
    end

    assign LINK.cs_n = h_reg.cs_n;
    assign LINK.sclk = h_reg.sclk;
    assign LINK.mosi = h_reg.mosi;
    assign BUSY_OUT  = h_reg.busy;
    assign DONE_OUT  = h_reg.done;
    assign RDATA_OUT = h_reg.rdata;

endmodule // asp_host

// file: hdl/asp_if.sv
`timescale 1ns/1ps

interface asp_if;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic miso_o;
    logic miso_oe;
    logic miso;

    // released line sits low through the device pull-down
    assign miso = miso_oe ? miso_o : 1'b0;

    modport dev
    (
        input  cs_n,
        input  sclk,
        input  mosi,
        output miso_o,
        output miso_oe
    );

    modport host
    (
        output cs_n,
        output sclk,
        output mosi,
        input  miso
    );
endinterface

// file: hdl/asp_map.svh
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH

`define ASP_CLK_PERIOD_NS   8
`define ASP_FRAME_BITS      16

`define ASP_CMD_MSB         15
`define ASP_CMD_LSB         13
`define ASP_ADDR_MSB        12
`define ASP_ADDR_LSB        8
`define ASP_DATA_MSB        7
`define ASP_DATA_LSB        0
`define ASP_CMD_READ        3'h2
`define ASP_CMD_WRITE       3'h4

`define ASP_REFRESH_NS      1000
`define ASP_REFRESH_CYC     (`ASP_REFRESH_NS / `ASP_CLK_PERIOD_NS)
`define ASP_NVM_WAIT_MS     20
`define ASP_NVM_WAIT_CYC    (`ASP_NVM_WAIT_MS * 1000000 / `ASP_CLK_PERIOD_NS)
`define ASP_ANGLE_GAP_NS    150
`define ASP_ANGLE_GAP_CYC   ((`ASP_ANGLE_GAP_NS + 7) / `ASP_CLK_PERIOD_NS)
`define ASP_REG_GAP_NS      750
`define ASP_REG_GAP_CYC     ((`ASP_REG_GAP_NS + 7) / `ASP_CLK_PERIOD_NS)
`define ASP_CS_LEAD_NS      80
`define ASP_CS_LEAD_CYC     ((`ASP_CS_LEAD_NS + 7) / `ASP_CLK_PERIOD_NS)
`define ASP_CS_TAIL_NS      25
`define ASP_CS_TAIL_CYC     ((`ASP_CS_TAIL_NS + 7) / `ASP_CLK_PERIOD_NS)
`define ASP_SCLK_HALF_NS    20
`define ASP_SCLK_HALF_CYC   ((`ASP_SCLK_HALF_NS + 7) / `ASP_CLK_PERIOD_NS)

`define ASP_REG_ZERO_LO     5'h00
`define ASP_REG_ZERO_HI     5'h01
`define ASP_REG_BIAS        5'h02
`define ASP_REG_TRIM_EN     5'h03
`define ASP_REG_FIELD_THR   5'h06
`define ASP_REG_POLES       5'h07
`define ASP_REG_DIR         5'h09
`define ASP_REG_FLAGS       5'h1b

`define ASP_REG_RST         8'h00
`define ASP_FIELD_THR_RST   8'h1c
`define ASP_DIR_BIT         7
`define ASP_FIELD_HIGH_BIT  7
`define ASP_FIELD_LOW_BIT   6

`endif

// file: hdl/asp_pkg.sv
package asp_pkg;

    typedef enum logic [2:0]
    {
        DEV_ANGLE = 3'b001,
        DEV_ARMED = 3'b010,
        DEV_REPLY = 3'b100
    } asp_dev_state_type;

    typedef enum logic [5:0]
    {
        HST_IDLE = 6'b000001,
        HST_LEAD = 6'b000010,
        HST_LOW  = 6'b000100,
        HST_HIGH = 6'b001000,
        HST_TAIL = 6'b010000,
        HST_GAP  = 6'b100000
    } asp_host_state_type;

    typedef enum logic [1:0]
    {
        OP_ANGLE = 2'h0,
        OP_READ  = 2'h1,
        OP_WRITE = 2'h2
    } asp_op_type;

    typedef struct packed
    {
        logic              cs_s1;
        logic              cs_s2;
        logic              cs_d;
        logic              tg_s1;
        logic              tg_s2;
        logic              tg_d;
        logic              fh_s1;
        logic              fh_s2;
        logic              fl_s1;
        logic              fl_s2;
        logic [7:0]        us_cnt;
        logic [15:0]       out_word;
        asp_dev_state_type st;
        logic [4:0]        addr;
        logic [7:0]        wdata;
        logic              nvm_busy;
        logic [31:0]       nvm_cnt;
        logic [31:0][7:0]  regs;
    } asp_core_type;

    typedef struct packed
    {
        logic [4:0]  cnt;
        logic [14:0] shift;
        logic        fell;
        logic        out_bit;
        logic [15:0] cmd;
        logic        tg;
    } asp_link_type;

    typedef struct packed
    {
        asp_host_state_type st;
        asp_op_type         op;
        logic               second;
        logic [15:0]        tx;
        logic [15:0]        rx;
        logic [4:0]         bitn;
        logic [31:0]        tmr;
        logic               miso_s1;
        logic               miso_s2;
        logic               cs_n;
        logic               sclk;
        logic               mosi;
        logic               busy;
        logic               done;
        logic [15:0]        rdata;
    } asp_host_type;

endpackage

// file: verif/asp_asserts.sv
`timescale 1ns/1ps
module asp_asserts
(
    input wire logic CORE_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe,
    input wire logic miso
);
    localparam int GAP = 18;
    logic [5:0] rise_reg;
    logic [7:0] high_reg;
    logic       sclk_reg;
    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            rise_reg <= '0;
            high_reg <= '0;
            sclk_reg <= 1'b0;
        end
        else
        begin
            sclk_reg <= sclk;
            high_reg <= !cs_n ? 8'h00 : high_reg + (high_reg != 8'hff);
            rise_reg <= cs_n ? 6'h00 : rise_reg + (sclk && !sclk_reg);
        end
    end
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    oe_follows_cs_a: assert property (miso_oe == !cs_n)
        else $error("miso enable not tied to select");
    miso_idle_low_a: assert property (cs_n |-> !miso)
        else $error("miso not low while deselected");
    mosi_held_a: assert property (sclk && $past(sclk) |-> $stable(mosi))
        else $error("mosi moved while clock high");
    miso_held_a: assert property (!cs_n && $past(!cs_n) && sclk
        && $past(sclk) |-> $stable(miso_o))
        else $error("miso moved while clock high");
    clock_idle_a: assert property (cs_n |-> !sclk)
        else $error("serial clock not idle low");
    frame_bits_a: assert property ($rose(cs_n) |-> rise_reg == 6'd16)
        else $error("frame not sixteen clocks");
    select_gap_a: assert property ($fell(cs_n) |-> high_reg >= GAP)
        else $error("select gap too short");
    select_tail_a: assert property ($rose(sclk) |-> !cs_n [*4])
        else $error("select rose too soon after clock");
endmodule // asp_asserts

// file: verif/tb.sv
`timescale 1ns/1ps
module tb;
    import asp_pkg::*;
    localparam int NVM = 200;
    localparam logic [4:0] ADDRS [9] = '{0, 1, 2, 3, 6, 7, 9, 5, 27};
    logic        clk;
    logic        rst_n;
    logic        req;
    asp_op_type  op;
    logic [4:0]  addr;
    logic [7:0]  wdata;
    logic [15:0] angle;
    logic [15:0] exp_angle;
    logic        fh;
    logic        fl;
    logic        busy;
    logic        done;
    logic        ccw;
    logic [15:0] rdata;
    logic [7:0]  mdl [32];
    logic [31:0] seed;
    int          n_mismatch;
    int          samples_checked;
    asp_if asp_if_i ();
    asp_dev #(.ANGLE_BITS(12), .NVM_WAIT_CYC(NVM)) asp_dev_i
    (
        .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .ANGLE_IN(angle),
        .FIELD_HIGH_FLAG_IN(fh), .FIELD_LOW_FLAG_IN(fl),
        .ROT_CCW_OUT(ccw), .LINK(asp_if_i.dev)
    );
    asp_host #(.MODE3(1'b0), .NVM_WAIT_CYC(NVM)) asp_host_i
    (
        .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .REQ_IN(req), .OP_IN(op),
        .ADDR_IN(addr), .WDATA_IN(wdata), .BUSY_OUT(busy),
        .DONE_OUT(done), .RDATA_OUT(rdata), .LINK(asp_if_i.host)
    );
    asp_asserts asp_asserts_i
    (
        .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .cs_n(asp_if_i.cs_n),
        .sclk(asp_if_i.sclk), .mosi(asp_if_i.mosi),
        .miso_o(asp_if_i.miso_o), .miso_oe(asp_if_i.miso_oe),
        .miso(asp_if_i.miso)
    );
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function logic [7:0] rd(input logic [4:0] a);
        return a == 5'h1b ? {fh, fl, 6'h00} : mdl[a];
    endfunction
    task print_verdict();
        $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task check(input logic [15:0] got, input logic [15:0] want);
        samples_checked++;
        if (got !== want)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
        end
    endtask
    // done stands one cycle, so it is looked at on the falling edge
    task run(input asp_op_type o, input logic [4:0] a, input logic [7:0] d);
        int i;
        @(posedge clk);
        op <= o;
        addr <= a;
        wdata <= d;
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
        @(negedge clk);
        check(busy, 1'b1);
        i = 0;
        while (done !== 1'b1 && i < 4000)
        begin
            @(negedge clk);
            i++;
        end
        if (done !== 1'b1)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: no done from host", $time);
        end
    endtask
    task rreg(input logic [4:0] a);
        run(OP_READ, a, 8'h00);
        check(rdata, {8'h00, rd(a)});
    endtask
    task wreg(input logic [4:0] a, input logic [7:0] d);
        run(OP_WRITE, a, d);
        if (a inside {0, 1, 2, 3, 6, 7, 9})
            mdl[a] = d;
        check(rdata, {8'h00, rd(a)});
    endtask
    // reset restores the power-up defaults, not the registers written before it
    task do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        mdl = '{default: 8'h00};
        mdl[6] = 8'h1c;
        repeat (260) @(posedge clk);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial
    begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        $display("CHECK FAILED at %0t: run timed out", $time);
        print_verdict();
    end
    initial
    begin
        seed = 32'd57;
        rst_n = 1'b0;
        req = 1'b0;
        op = OP_ANGLE;
        addr = 5'h00;
        wdata = 8'h00;
        angle = 16'h0000;
        fh = 1'b0;
        fl = 1'b0;
        n_mismatch = 0;
        samples_checked = 0;
        do_reset();
        angle <= 16'(rnd());
        repeat (260) @(posedge clk);
        exp_angle = angle & 16'hfff0;
        run(OP_ANGLE, 5'h00, 8'h00);
        check(rdata, exp_angle);
        run(OP_ANGLE, 5'h00, 8'h00);
        check(rdata, exp_angle);
        fork
            run(OP_ANGLE, 5'h00, 8'h00);
            begin
                repeat (20) @(posedge clk);
                angle <= 16'(rnd());
            end
        join
        check(rdata, exp_angle);
        repeat (260) @(posedge clk);
        run(OP_ANGLE, 5'h00, 8'h00);
        check(rdata, angle & 16'hfff0);
        $display("test angle done");
        repeat (2)
        begin
            {fh, fl} <= 2'(rnd());
            repeat (8) @(posedge clk);
            rreg(5'h1b);
        end
        for (int k = 0; k < 9; k++)
        begin
            wreg(ADDRS[k], 8'(rnd()));
            rreg(ADDRS[k]);
        end
        wreg(5'h09, 8'h80);
        check(ccw, 1'b1);
        $display("test registers done");
        do_reset();
        check(ccw, 1'b0);
        rreg(5'h06);
        rreg(5'h09);
        $display("test reload done");
        print_verdict();
    end
endmodule // tb
